/* File: rtl/ivu_pkg.sv */
// Purpose: shared constants and carriers for the interrupt vectoring unit
// Assumes: 8-bit vectors, 16-bit offsets, 8-bit segment numbers
// Notes: table entries are two-byte addresses, high byte at the even offset
package ivu_pkg;
	localparam int unsigned NUM_CH        = 8;
	localparam int unsigned CH_W          = 3;
	localparam int unsigned VEC_W         = 8;
	localparam int unsigned SEG_W         = 8;
	localparam int unsigned OFS_W         = 16;
	localparam int unsigned TABLE_SIZE    = 256;
	localparam logic [OFS_W-1:0] OFS_RESET_VEC = 16'h0000;
	localparam logic [SEG_W-1:0] SEG_RESET_VEC = 8'h00;
	localparam logic [OFS_W-1:0] OFS_DIV0_VEC  = 16'h0002;
	localparam logic [OFS_W-1:0] OFS_TOP_VEC   = 16'h0004;
	localparam logic [OFS_W-1:0] OFS_WDOG_VEC  = 16'h0006;
	localparam logic [OFS_W-1:0] WDOG_FILL     = 16'hFFFF;
	localparam logic [OFS_W-1:0] OFS_NEXT_BYTE = 16'h0001;
	localparam logic [VEC_W-1:0] BASE_RESET    = 8'h00;
	localparam logic [SEG_W-1:0] SEG_REG_RESET = 8'h00;
	localparam logic [NUM_CH-1:0] EDGE_RESET   = 8'h00;
	localparam logic [VEC_W-1:0] VEC_LSB_ZERO  = 8'hFE;

	typedef enum logic [1:0] {
		IVU_SRC_STD,
		IVU_SRC_TOP,
		IVU_SRC_DIV0,
		IVU_SRC_RESET
	} ivu_src_t;

	// one fetch request toward the memory side
	typedef struct packed {
		logic                 valid;
		logic [SEG_W-1:0]     seg;
		logic [OFS_W-1:0]     ofs;
		logic                 push_flags;
		logic                 use_isr_seg;
		ivu_src_t             src;
	} ivu_fetch_t;
endpackage

/* File: rtl/ivu_top.sv */
// Purpose: gathers interrupt requests and builds the vector table fetch
// Assumes: inputs synchronous to CLK, CPU core sequences stack pushes itself
// Notes: the vector table may hold code outside the entries really used
`timescale 1ns/1ps

module ivu_top (
	input  wire logic                        CLK,
	input  wire logic                        RST,
	input  wire logic [ivu_pkg::NUM_CH-1:0]  EXT_IN,
	input  wire logic [ivu_pkg::NUM_CH-1:0]  EXT_EDGE_RISING,
	input  wire logic [ivu_pkg::NUM_CH-1:0]  PERIPH_REQ,
	input  wire logic [ivu_pkg::NUM_CH-1:0]  CH_ENABLE,
	input  wire logic                        NMI_PIN,
	input  wire logic                        WDOG_REQ,
	input  wire logic                        TOP_SRC_WDOG,
	input  wire logic                        TOP_ENABLE,
	input  wire logic                        DIV0_TRAP,
	input  wire logic                        BASE_WE,
	input  wire logic [ivu_pkg::VEC_W-1:0]   BASE_WDATA,
	input  wire logic                        SEG_WE,
	input  wire logic [ivu_pkg::SEG_W-1:0]   SEG_WDATA,
	input  wire logic [ivu_pkg::SEG_W-1:0]   CODE_SEG,
	input  wire logic                        ACK,
	output logic                             REQ_PENDING,
	output logic [ivu_pkg::VEC_W-1:0]        VECTOR,
	output ivu_pkg::ivu_fetch_t              FETCH,
	output logic [ivu_pkg::NUM_CH-1:0]       PENDING,
	output logic [ivu_pkg::VEC_W-1:0]        VECTOR_BASE,
	output logic [ivu_pkg::SEG_W-1:0]        INT_SEG
);
	logic [ivu_pkg::NUM_CH-1:0] ext_prev_reg;
	logic [ivu_pkg::NUM_CH-1:0] ext_prev_next;
	logic [ivu_pkg::NUM_CH-1:0] pend_reg;
	logic [ivu_pkg::NUM_CH-1:0] pend_next;
	logic [ivu_pkg::NUM_CH-1:0] ext_edge;
	logic [ivu_pkg::NUM_CH-1:0] clr_mask;
	logic                       top_pend_reg;
	logic                       top_pend_next;
	logic                       top_src_prev_reg;
	logic                       top_src_prev_next;
	logic                       top_src;
	logic                       boot_reg;
	logic                       boot_next;
	logic [ivu_pkg::VEC_W-1:0]  vector_pointer_register;
	logic [ivu_pkg::VEC_W-1:0]  base_next;
	logic [ivu_pkg::SEG_W-1:0]  interrupt_segment_register;
	logic [ivu_pkg::SEG_W-1:0]  seg_next;
	logic [ivu_pkg::VEC_W-1:0]  vec_reg;
	logic [ivu_pkg::VEC_W-1:0]  vec_next;
	ivu_pkg::ivu_fetch_t        fetch_reg;
	ivu_pkg::ivu_fetch_t        fetch_next;
	logic [ivu_pkg::CH_W-1:0]   win_ch;
	logic                       win_any;
	logic                       take_div0;
	logic                       take_top;
	logic                       take_std;
	logic                       top_edge;
	logic [ivu_pkg::VEC_W-1:0]  std_vec;

	// per-input edge pick, polarity chosen per channel
	genvar gi;
	generate
		for (gi = 0; gi < ivu_pkg::NUM_CH; gi++) begin : g_edge
			assign ext_edge[gi] = EXT_EDGE_RISING[gi] ?
				(EXT_IN[gi] & ~ext_prev_reg[gi]) :
				(~EXT_IN[gi] & ext_prev_reg[gi]);
		end
	endgenerate

	assign top_src  = TOP_SRC_WDOG ? WDOG_REQ : NMI_PIN;
	assign top_edge = TOP_ENABLE & top_src & ~top_src_prev_reg;

	// lowest index wins among enabled pending channels
	always_comb begin
		win_ch  = '0;
		win_any = 1'b0;
		for (int i = ivu_pkg::NUM_CH - 1; i >= 0; i--) begin
			if (pend_reg[i] && CH_ENABLE[i]) begin
				win_ch  = i[ivu_pkg::CH_W-1:0];
				win_any = 1'b1;
			end
		end
	end

	// one fetch per cycle: boot, then trap, then top level, then standard
	always_comb begin
		take_div0 = 1'b0;
		take_top  = 1'b0;
		take_std  = 1'b0;
		if (!boot_reg) begin
			if (DIV0_TRAP) begin
				take_div0 = 1'b1;
			end else if (ACK && top_pend_reg) begin
				take_top = 1'b1;
			end else if (ACK && win_any) begin
				take_std = 1'b1;
			end
		end
	end

	// base keeps the bits above the channel field, index lands above a forced zero
	always_comb begin
		std_vec = vector_pointer_register
			& ~{{(ivu_pkg::VEC_W-ivu_pkg::CH_W-1){1'b0}}, {ivu_pkg::CH_W{1'b1}}, 1'b0};
		std_vec = std_vec
			| {{(ivu_pkg::VEC_W-ivu_pkg::CH_W-1){1'b0}}, win_ch, 1'b0};
		std_vec = std_vec & ivu_pkg::VEC_LSB_ZERO;
	end

	always_comb begin
		ext_prev_next = EXT_IN;
		clr_mask      = '0;
		if (take_std) begin
			clr_mask[win_ch] = 1'b1;
		end
		// set wins over clear: a fresh edge in the ack cycle stays pending
		pend_next = (pend_reg & ~clr_mask) | ext_edge | PERIPH_REQ;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			ext_prev_reg <= ivu_pkg::EDGE_RESET;
			pend_reg     <= '0;
		end else begin
			ext_prev_reg <= ext_prev_next;
			pend_reg     <= pend_next;
		end
	end

	always_comb begin
		top_src_prev_next = top_src;
		top_pend_next     = top_pend_reg;
		if (take_top) begin
			top_pend_next = 1'b0;
		end
		// new top-level edge beats an ack in the same cycle
		if (top_edge) begin
			top_pend_next = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			top_src_prev_reg <= 1'b0;
			top_pend_reg     <= 1'b0;
		end else begin
			top_src_prev_reg <= top_src_prev_next;
			top_pend_reg     <= top_pend_next;
		end
	end

	// boot fetch goes out once, on the first edge after reset
	always_comb begin
		boot_next = 1'b0;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			boot_reg <= 1'b1;
		end else begin
			boot_reg <= boot_next;
		end
	end

	always_comb begin
		base_next = vector_pointer_register;
		seg_next  = interrupt_segment_register;
		if (BASE_WE) begin
			base_next = BASE_WDATA;
		end
		if (SEG_WE) begin
			seg_next = SEG_WDATA;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			vector_pointer_register    <= ivu_pkg::BASE_RESET;
			interrupt_segment_register <= ivu_pkg::SEG_REG_RESET;
		end else begin
			vector_pointer_register    <= base_next;
			interrupt_segment_register <= seg_next;
		end
	end

	always_comb begin
		vec_next   = vec_reg;
		fetch_next = '0;
		if (boot_reg) begin
			// absolute bytes zero and one, ignores the segment registers
			fetch_next.valid = 1'b1;
			fetch_next.seg   = ivu_pkg::SEG_RESET_VEC;
			fetch_next.ofs   = ivu_pkg::OFS_RESET_VEC;
			fetch_next.src   = ivu_pkg::IVU_SRC_RESET;
		end else if (take_div0) begin
			fetch_next.valid      = 1'b1;
			fetch_next.seg        = CODE_SEG;
			fetch_next.ofs        = ivu_pkg::OFS_DIV0_VEC;
			fetch_next.push_flags = 1'b0;
			fetch_next.src        = ivu_pkg::IVU_SRC_DIV0;
		end else if (take_top) begin
			fetch_next.valid       = 1'b1;
			fetch_next.seg         = interrupt_segment_register;
			fetch_next.ofs         = ivu_pkg::OFS_TOP_VEC;
			fetch_next.push_flags  = 1'b1;
			fetch_next.use_isr_seg = 1'b1;
			fetch_next.src         = ivu_pkg::IVU_SRC_TOP;
		end else if (take_std) begin
			vec_next               = std_vec;
			fetch_next.valid       = 1'b1;
			fetch_next.seg         = interrupt_segment_register;
			// 8-bit vector confines the entry to the first 256 bytes
			fetch_next.ofs         = {{(ivu_pkg::OFS_W-ivu_pkg::VEC_W){1'b0}}, std_vec};
			fetch_next.push_flags  = 1'b1;
			fetch_next.use_isr_seg = 1'b1;
			fetch_next.src         = ivu_pkg::IVU_SRC_STD;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			vec_reg   <= '0;
			fetch_reg <= '0;
		end else begin
			vec_reg   <= vec_next;
			fetch_reg <= fetch_next;
		end
	end

	// code fetches to the segment are never blocked here
	assign REQ_PENDING = top_pend_reg | win_any;
	assign VECTOR      = vec_reg;
	assign FETCH       = fetch_reg;
	assign PENDING     = pend_reg;
	assign VECTOR_BASE = vector_pointer_register;
	assign INT_SEG     = interrupt_segment_register;
endmodule // ivu_top

/* File: testbench/ivu_checker.sv */
// Purpose: port checks for ivu_top
// Assumes: sync reset, one clock
// Notes: top pending is internal, seen only through REQ_PENDING
`timescale 1ns/1ps
module ivu_checker (
	input wire logic                CLK,
	input wire logic                RST,
	input wire logic                ACK,
	input wire logic                DIV0_TRAP,
	input wire logic [7:0]          CODE_SEG,
	input wire logic [7:0]          INT_SEG,
	input wire logic                REQ_PENDING,
	input wire logic [7:0]          VECTOR,
	input wire ivu_pkg::ivu_fetch_t FETCH,
	input wire logic [7:0]          PENDING,
	input wire logic [7:0]          VECTOR_BASE,
	input wire logic [7:0]          CH_ENABLE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	property p_boot;
		$past(RST) |=> FETCH.valid && FETCH.src == ivu_pkg::IVU_SRC_RESET && FETCH.ofs == 16'h0000;
	endproperty
	a_boot: assert property (p_boot) else $error("boot fetch wrong");
	property p_div0;
		!$past(RST) && DIV0_TRAP |=> FETCH.valid && FETCH.ofs == 16'h0002
			&& FETCH.seg == $past(CODE_SEG) && !FETCH.push_flags;
	endproperty
	a_div0: assert property (p_div0) else $error("trap fetch wrong");
	property p_std;
		FETCH.valid && FETCH.src == ivu_pkg::IVU_SRC_STD |-> FETCH.ofs == {8'h00, VECTOR}
			&& !VECTOR[0] && FETCH.seg == INT_SEG;
	endproperty
	a_std: assert property (p_std) else $error("std fetch wrong");
	property p_base;
		FETCH.valid && FETCH.src == ivu_pkg::IVU_SRC_STD |-> VECTOR[7:4] == VECTOR_BASE[7:4]
			&& FETCH.push_flags;
	endproperty
	a_base: assert property (p_base) else $error("vector base wrong");
	property p_top;
		FETCH.valid && FETCH.src == ivu_pkg::IVU_SRC_TOP |-> FETCH.ofs == 16'h0004
			&& FETCH.seg == INT_SEG;
	endproperty
	a_top: assert property (p_top) else $error("top fetch wrong");
	property p_refuse;
		!$past(RST) && ACK && !REQ_PENDING && !DIV0_TRAP |=> !FETCH.valid;
	endproperty
	a_refuse: assert property (p_refuse) else $error("fetch without request");
	property p_hold;
		!ACK |=> ($past(PENDING) & ~PENDING) == 8'h00;
	endproperty
	a_hold: assert property (p_hold) else $error("pending lost");
	property p_req;
		|(PENDING & CH_ENABLE) |-> REQ_PENDING;
	endproperty
	a_req: assert property (p_req) else $error("request not flagged");
endmodule // ivu_checker
bind ivu_top ivu_checker ivu_checker_inst (.CLK, .RST, .ACK, .DIV0_TRAP, .CODE_SEG, .INT_SEG,
	.REQ_PENDING, .VECTOR, .FETCH, .PENDING, .VECTOR_BASE, .CH_ENABLE);

/* File: testbench/ivu_cpu_model.sv */
// Purpose: core side that acknowledges after a lag
// Assumes: lag counts cycles of standing request
// Notes: lag 0 answers at once
`timescale 1ns/1ps
module ivu_cpu_model (
	input  wire logic                CLK,
	input  wire logic                REQ_PENDING,
	input  wire logic                auto_en,
	input  wire logic [3:0]          lag,
	input  wire ivu_pkg::ivu_fetch_t fetch,
	output logic                     ack,
	output logic [15:0]              word
);
	logic [3:0]  cnt = 4'h0;
	// low table image: reset, trap, top level, watchdog slot; one image for every segment
	logic [15:0] image [0:3];
	initial begin
		ack      = 1'b0;
		image[0] = 16'h0100;
		image[1] = 16'h0200;
		image[2] = 16'h0300;
		image[3] = ivu_pkg::WDOG_FILL;
	end
	// word the core loads for the fetch now standing, low slots only
	assign word = (fetch.valid && fetch.ofs < 16'h0008) ? image[fetch.ofs[2:1]] : 16'h0000;
	always @(negedge CLK) begin
		if (ack) begin
			ack <= 1'b0;
			cnt <= 4'h0;
		end else if (auto_en && REQ_PENDING) begin
			// one ack per request, so pending drains one channel at a time
			if (cnt >= lag) ack <= 1'b1;
			else cnt <= cnt + 4'h1;
		end else cnt <= 4'h0;
	end
endmodule // ivu_cpu_model

/* File: testbench/tb.sv */
// Purpose: scenario bench for ivu_top
// Assumes: inputs change at falling edge
// Notes: fetch checks done at the falling edge, half a cycle after the taking edge
`timescale 1ns/1ps
module tb;
	logic [7:0] EXT_IN = 8'h00, EXT_EDGE_RISING = 8'h00, PERIPH_REQ = 8'h00, CH_ENABLE = 8'hFF;
	logic [7:0] BASE_WDATA = 8'h00, SEG_WDATA = 8'h00, CODE_SEG = 8'h5A;
	logic CLK = 0, RST = 1, NMI_PIN = 0, WDOG_REQ = 0, TOP_SRC_WDOG = 0, TOP_ENABLE = 1;
	logic DIV0_TRAP = 0, BASE_WE = 0, SEG_WE = 0, ack_tb = 0, ack_cpu, auto_en = 0;
	logic REQ_PENDING;
	logic [7:0] VECTOR, PENDING, VECTOR_BASE, INT_SEG;
	logic [15:0] word;
	ivu_pkg::ivu_fetch_t FETCH;
	int failures = 0, samples_checked = 0, cycles = 0;
	wire ACK = ack_tb | ack_cpu;
	always #2 CLK = ~CLK;
	ivu_top ivu_top_inst (.CLK, .RST, .EXT_IN, .EXT_EDGE_RISING, .PERIPH_REQ, .CH_ENABLE, .NMI_PIN,
		.WDOG_REQ, .TOP_SRC_WDOG, .TOP_ENABLE, .DIV0_TRAP, .BASE_WE, .BASE_WDATA, .SEG_WE,
		.SEG_WDATA, .CODE_SEG, .ACK, .REQ_PENDING, .VECTOR, .FETCH, .PENDING, .VECTOR_BASE, .INT_SEG);
	ivu_cpu_model ivu_cpu_model_inst (.CLK, .REQ_PENDING, .auto_en, .lag(4'h3), .fetch(FETCH),
		.ack(ack_cpu), .word);
	task give_verdict;
		if (failures == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			failures++;
		end
	endtask
	task tick(input int n);
		repeat (n) @(negedge CLK);
	endtask
	task ack1;
		ack_tb = 1;
		tick(1);
		ack_tb = 0;
	endtask
	task t_reset;
		tick(8);
		RST = 0;
		tick(1);
		chk("boot valid", 32'h1, FETCH.valid);
		chk("boot ofs", 16'h0000, FETCH.ofs);
		chk("boot word", 16'h0100, word);
	endtask
	task t_std;
		BASE_WE = 1;
		BASE_WDATA = 8'hA5;
		SEG_WE = 1;
		SEG_WDATA = 8'h3C;
		tick(1);
		BASE_WE = 0;
		SEG_WE = 0;
		for (int ch = 0; ch < 8; ch++) begin
			PERIPH_REQ = 8'h01 << ch;
			tick(1);
			PERIPH_REQ = 8'h00;
			ack1;
			chk("vector", {4'hA, ch[2:0], 1'b0}, VECTOR);
			chk("std ofs", {8'h00, 4'hA, ch[2:0], 1'b0}, FETCH.ofs);
			chk("seg", 8'h3C, FETCH.seg);
			chk("std flags", 32'h7, {FETCH.valid, FETCH.push_flags, FETCH.use_isr_seg});
			chk("acked", 8'h00, PENDING);
		end
		// masked channel keeps its bit but raises nothing
		CH_ENABLE = 8'hFE;
		PERIPH_REQ = 8'h01;
		tick(1);
		PERIPH_REQ = 8'h00;
		chk("masked req", 32'h0, REQ_PENDING);
		ack1;
		chk("refused", 32'h0, FETCH.valid);
		chk("kept", 8'h01, PENDING);
		CH_ENABLE = 8'hFF;
		tick(1);
		ack1;
		chk("unmasked", 8'hA0, VECTOR);
		chk("unmasked pend", 8'h00, PENDING);
	endtask
	task t_ext;
		EXT_EDGE_RISING = 8'h0F;
		EXT_IN = 8'hFF;
		tick(1);
		chk("rise", 8'h0F, PENDING);
		EXT_IN = 8'h00;
		tick(1);
		chk("fall", 8'hFF, PENDING);
		auto_en = 1;
		for (int i = 0; i < 100 && PENDING !== 8'h00; i++) tick(1);
		auto_en = 0;
		chk("drained", 8'h00, PENDING);
	endtask
	task t_top;
		TOP_ENABLE = 0;
		NMI_PIN = 1;
		tick(1);
		NMI_PIN = 0;
		TOP_ENABLE = 1;
		chk("top masked", 32'h0, REQ_PENDING);
		tick(1);
		NMI_PIN = 1;
		tick(1);
		NMI_PIN = 0;
		ack1;
		chk("top ofs", 16'h0004, FETCH.ofs);
		chk("top seg", 8'h3C, FETCH.seg);
		chk("top word", 16'h0300, word);
		TOP_SRC_WDOG = 1;
		NMI_PIN = 1;
		tick(1);
		NMI_PIN = 0;
		chk("pin unselected", 32'h0, REQ_PENDING);
		WDOG_REQ = 1;
		tick(1);
		WDOG_REQ = 0;
		ack1;
		chk("wdog src", ivu_pkg::IVU_SRC_TOP, FETCH.src);
	endtask
	task t_div0;
		// a top request waits out a trap that shares its ack cycle
		tick(1);
		WDOG_REQ = 1;
		tick(1);
		WDOG_REQ = 0;
		DIV0_TRAP = 1;
		ack1;
		DIV0_TRAP = 0;
		chk("trap ofs", 16'h0002, FETCH.ofs);
		chk("trap seg", 8'h5A, FETCH.seg);
		chk("trap flags", 32'h0, FETCH.push_flags);
		chk("trap word", 16'h0200, word);
		chk("top kept", 32'h1, REQ_PENDING);
		tick(1);
		ack1;
		chk("top after trap", ivu_pkg::IVU_SRC_TOP, FETCH.src);
	endtask
	task t_rerun;
		PERIPH_REQ = 8'h04;
		tick(1);
		PERIPH_REQ = 8'h00;
		RST = 1;
		tick(2);
		RST = 0;
		tick(1);
		chk("reboot valid", 32'h1, FETCH.valid);
		chk("reboot src", ivu_pkg::IVU_SRC_RESET, FETCH.src);
		chk("reboot pend", 8'h00, PENDING);
		chk("reboot base", 8'h00, VECTOR_BASE);
		chk("reboot seg", 8'h00, INT_SEG);
		tick(1);
		chk("boot once", 32'h0, FETCH.valid);
	endtask
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			give_verdict;
		end
	end
	initial begin
		t_reset;
		t_std;
		t_ext;
		t_top;
		t_div0;
		t_rerun;
		give_verdict;
	end
endmodule // tb
